/* File: rng_word_gen.sv */
// random word generator with a 16-word output fifo behind an apb slave port
// assumes an apb3 master on SYS_CLK; no ring oscillators, the core is a pair of lfsrs
`timescale 1ns/1ps

module rng_word_gen
  import rng_word_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);

  // ==========================================================
  // state
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic run_reg;
  logic ha_reg;
  logic mask_reg;
  logic error_irq_reg;
  logic underflow_reg;
  logic last_empty_reg;
  logic violation_reg;
  logic [7:0] gen_count_reg;
  logic [31:0] core_a_reg;
  logic [31:0] core_b_reg;
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_reg;
  logic [FIFO_AW-1:0] rd_ptr_reg;
  logic [FIFO_AW:0] level_reg;
  logic [EVT_WIDTH-1:0] irq_status_reg;
  logic [EVT_WIDTH-1:0] irq_enable_reg;

  // ==========================================================
  // bus decode
  bus_req_s req;
  logic sel_ctrl;
  logic sel_status;
  logic sel_seed;
  logic sel_fifo;
  logic sel_irq_status;
  logic sel_irq_clear;
  logic sel_irq_enable;
  logic mapped;
  logic wr_ctrl;
  logic wr_seed;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic rd_status;
  logic rd_fifo;

  // a request is taken once, in the first access cycle; pready follows next cycle
  assign req.take = PSEL & PENABLE & ~pready_reg;
  assign req.wr = PWRITE;
  assign req.addr = PADDR;
  assign req.wdata = PWDATA;

  assign sel_ctrl = req.addr == RNG_CONTROL_ADDR;
  assign sel_status = req.addr == RNG_STATUS_ADDR;
  assign sel_seed = req.addr == ENTROPY_SEED_INPUT_ADDR;
  assign sel_fifo = req.addr == RANDOM_OUTPUT_FIFO_ADDR;
  assign sel_irq_status = req.addr == IRQ_STATUS_ADDR;
  assign sel_irq_clear = req.addr == IRQ_CLEAR_ADDR;
  assign sel_irq_enable = req.addr == IRQ_ENABLE_ADDR;
  assign mapped = sel_ctrl | sel_status | sel_seed | sel_fifo
                | sel_irq_status | sel_irq_clear | sel_irq_enable;

  assign wr_ctrl = req.take & req.wr & sel_ctrl;
  assign wr_seed = req.take & req.wr & sel_seed;
  assign wr_irq_clear = req.take & req.wr & sel_irq_clear;
  assign wr_irq_enable = req.take & req.wr & sel_irq_enable;
  assign rd_status = req.take & ~req.wr & sel_status;
  assign rd_fifo = req.take & ~req.wr & sel_fifo;

  // ==========================================================
  // fifo control
  logic fifo_empty;
  logic fifo_full;
  logic push_due;
  logic push;
  logic pop;
  logic empty_read;

  assign fifo_empty = level_reg == '0;
  assign fifo_full = level_reg == (FIFO_AW + 1)'(FIFO_DEPTH);
  assign push_due = run_reg & (gen_count_reg == PUSH_LAST_COUNT);
  assign push = push_due & ~fifo_full;
  assign pop = rd_fifo & ~fifo_empty;
  assign empty_read = rd_fifo & fifo_empty;

  // ==========================================================
  // core engine
  logic [31:0] core_a_step;
  logic [31:0] core_b_step;
  logic [31:0] core_a_mixed;
  logic [31:0] random_word;

  assign core_a_step = {1'b0, core_a_reg[31:1]} ^ (core_a_reg[0] ? CORE_A_TAPS : 32'h00000000);
  assign core_b_step = {1'b0, core_b_reg[31:1]} ^ (core_b_reg[0] ? CORE_B_TAPS : 32'h00000000);
  // xor keeps entropy; a zero result would lock the lfsr, so it reloads instead
  assign core_a_mixed = wr_seed ? core_a_step ^ req.wdata : core_a_step;
  assign random_word = core_a_reg ^ {core_b_reg[15:0], core_b_reg[31:16]};

  // ==========================================================
  // read data
  rng_status_s status_view;
  logic [31:0] ctrl_view;
  logic [31:0] fifo_view;
  logic [31:0] read_mux;

  assign status_view.reserved_hi = 8'h00;
  assign status_view.fifo_capacity = FIFO_CAPACITY;
  assign status_view.fifo_fill_level = 8'(level_reg);
  assign status_view.reserved_lo = 4'h0;
  assign status_view.error_irq_flag = error_irq_reg;
  assign status_view.underflow_flag = underflow_reg;
  assign status_view.last_read_empty = last_empty_reg;
  assign status_view.security_violation = violation_reg;

  // clear_irq is write-only and reads zero
  assign ctrl_view = {29'h0, mask_reg, ha_reg, run_reg};
  assign fifo_view = fifo_empty ? 32'h00000000 : fifo_mem[rd_ptr_reg];

  assign read_mux = sel_ctrl ? ctrl_view
                  : sel_status ? status_view
                  : sel_fifo ? fifo_view
                  : sel_irq_status ? {30'h0, irq_status_reg}
                  : sel_irq_enable ? {30'h0, irq_enable_reg}
                  : 32'h00000000;

  // ==========================================================
  // interrupt events
  logic [EVT_WIDTH-1:0] evt;
  logic irq_next;

  assign evt[EVT_UNDERFLOW_BIT] = empty_read;
  // a pop in the same cycle keeps the level, so the fifo does not become full then
  assign evt[EVT_FULL_BIT] = push & ~pop & (level_reg == (FIFO_AW + 1)'(FIFO_DEPTH - 1));
  // an event in the cycle of its clear wins over the clear
  assign irq_next = (error_irq_reg & ~mask_reg)
                  | (|(irq_status_reg & irq_enable_reg));

  // ==========================================================
  // apb answer
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= req.take;
      prdata_reg <= (req.take & ~req.wr) ? read_mux : 32'h00000000;
      pslverr_reg <= req.take & ~mapped;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_reg <= 1'b0;
      ha_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else if (wr_ctrl) begin
      run_reg <= run_reg | req.wdata[CTRL_RUN_BIT];
      ha_reg <= ha_reg | req.wdata[CTRL_HA_BIT];
      mask_reg <= req.wdata[CTRL_MASK_BIT];
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      error_irq_reg <= 1'b0;
      underflow_reg <= 1'b0;
      last_empty_reg <= 1'b0;
      violation_reg <= 1'b0;
    end else begin
      if (empty_read) begin
        error_irq_reg <= 1'b1;
      end else if (wr_ctrl & req.wdata[CTRL_CLEAR_BIT]) begin
        error_irq_reg <= 1'b0;
      end
      if (empty_read) begin
        underflow_reg <= 1'b1;
      end else if (rd_status) begin
        underflow_reg <= 1'b0;
      end
      if (rd_fifo) begin
        last_empty_reg <= fifo_empty;
      end
      if (empty_read & ha_reg) begin
        violation_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // core and push schedule
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      core_a_reg <= CORE_A_RESET;
      core_b_reg <= CORE_B_RESET;
      gen_count_reg <= GEN_COUNT_RESET;
    end else begin
      // the core steps from reset on, whether or not generation runs
      core_a_reg <= (core_a_mixed == '0) ? CORE_A_RESET : core_a_mixed;
      core_b_reg <= core_b_step;
      if (run_reg) begin
        gen_count_reg <= gen_count_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // output fifo
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + FIFO_AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + FIFO_AW'(1);
      end
      if (push & ~pop) begin
        level_reg <= level_reg + (FIFO_AW + 1)'(1);
      end else if (pop & ~push) begin
        level_reg <= level_reg - (FIFO_AW + 1)'(1);
      end
    end
  end

  // storage is not reset; level and pointers decide what is valid
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= random_word;
    end
  end

  // ==========================================================
  // interrupt registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status_reg <= '0;
      irq_enable_reg <= IRQ_ENABLE_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_irq_clear ? req.wdata[EVT_WIDTH-1:0] : '0)) | evt;
      if (wr_irq_enable) begin
        irq_enable_reg <= req.wdata[EVT_WIDTH-1:0];
      end
      irq_reg <= irq_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ = irq_reg;

endmodule : rng_word_gen

/* File: rng_word_pkg.sv */
// register map, field layout, reset values and timing constants of the random word generator
// assumes a 32-bit apb slave port at 125 mhz and a single clock domain
package rng_word_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] RNG_CONTROL_ADDR = 32'h001a0000;
  localparam logic [31:0] RNG_STATUS_ADDR = 32'h001a0004;
  localparam logic [31:0] ENTROPY_SEED_INPUT_ADDR = 32'h001a0008;
  localparam logic [31:0] RANDOM_OUTPUT_FIFO_ADDR = 32'h001a000c;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h001a0010;
  localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h001a0014;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h001a0018;

  // ==========================================================
  // control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_HA_BIT = 1;
  localparam int CTRL_MASK_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 3;

  // ==========================================================
  // event bits shared by irq status, clear and enable
  localparam int EVT_UNDERFLOW_BIT = 0;
  localparam int EVT_FULL_BIT = 1;
  localparam int EVT_WIDTH = 2;

  // ==========================================================
  // fifo and generation timing
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [7:0] FIFO_CAPACITY = 8'h10;
  localparam int PUSH_PERIOD_CYCLES = 256;
  localparam logic [7:0] PUSH_LAST_COUNT = 8'(PUSH_PERIOD_CYCLES - 1);

  // ==========================================================
  // reset values and lfsr taps
  localparam logic [7:0] GEN_COUNT_RESET = 8'h00;
  localparam logic [31:0] CORE_A_RESET = 32'h6a09e667;
  localparam logic [31:0] CORE_B_RESET = 32'hbb67ae85;
  localparam logic [31:0] CORE_A_TAPS = 32'h80200003;
  localparam logic [31:0] CORE_B_TAPS = 32'ha3000001;
  localparam logic [EVT_WIDTH-1:0] IRQ_ENABLE_RESET = 2'h0;

  // ==========================================================
  // status register layout
  typedef struct packed {
    logic [7:0] reserved_hi;
    logic [7:0] fifo_capacity;
    logic [7:0] fifo_fill_level;
    logic [3:0] reserved_lo;
    logic error_irq_flag;
    logic underflow_flag;
    logic last_read_empty;
    logic security_violation;
  } rng_status_s;

  // one decoded bus request, taken in the first access cycle
  typedef struct packed {
    logic take;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

endpackage : rng_word_pkg

/* File: rng_word_gen_monitor.sv */
// checker of the rng word generator apb answer and status fields
// assumes one clock domain and a master that holds its request
`timescale 1ns/1ps
module rng_word_gen_monitor
  import rng_word_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  // ==========================================================
  // read decode
  wire rd_done = PREADY && !PWRITE;
  wire ctrl_rd = rd_done && PADDR == RNG_CONTROL_ADDR;
  wire stat_rd = rd_done && PADDR == RNG_STATUS_ADDR;
  wire seed_rd = rd_done && PADDR == ENTROPY_SEED_INPUT_ADDR;
  logic [1:0] seen_ctrl;
  logic seen_sv;
  // sticky bits are remembered, since one read alone proves nothing
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) seen_ctrl <= 2'h0;
    else if (ctrl_rd) seen_ctrl <= seen_ctrl | PRDATA[1:0];
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) seen_sv <= 1'b0;
    else if (stat_rd) seen_sv <= seen_sv | PRDATA[0];
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence first_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence answer_pulse;
    PREADY ##1 !PREADY;
  endsequence
  chk_one_wait: assert property (first_access |=> answer_pulse)
    else $error("ready not one cycle after access");
  chk_no_early: assert property (PSEL && !PENABLE |-> !PREADY)
    else $error("ready during setup");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_idle_data: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  chk_fifo_size: assert property (stat_rd |-> PRDATA[31:16] == {8'h00, FIFO_CAPACITY})
    else $error("capacity field wrong");
  chk_level_max: assert property (stat_rd |-> PRDATA[15:8] <= FIFO_CAPACITY && PRDATA[7:4] == 4'h0)
    else $error("level field wrong");
  chk_ctrl_resv: assert property (ctrl_rd |-> PRDATA[31:3] == 29'h0)
    else $error("control reserved bits set");
  chk_seed_zero: assert property (seed_rd |-> PRDATA == 32'h0)
    else $error("seed read not zero");
  chk_sticky_ctrl: assert property (ctrl_rd |-> (PRDATA[1:0] & seen_ctrl) == seen_ctrl)
    else $error("sticky control bit lost");
  chk_sticky_sv: assert property (stat_rd && seen_sv |-> PRDATA[0])
    else $error("violation bit lost");
endmodule : rng_word_gen_monitor

bind rng_word_gen rng_word_gen_monitor mon (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

/* File: random_word_generator_fifo_test.sv */
// self-checking bench of the rng word generator
// drives the apb port itself; a model tracks level, flags and irq
`timescale 1ns/1ps
module random_word_generator_fifo_test
  import rng_word_pkg::*;
;
  logic SYS_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, exp_rd;
  logic PREADY, PSLVERR, IRQ, exp_err, rnd, run, ha, mask, ei, uf, lre, sv;
  logic [1:0] ist, ien;
  integer err_count = 0, checks_done = 0, seed = 49592, lvl, lv0, cyc, i;
  wire take = PSEL && PENABLE && !PREADY;
  wire irq_m = (ei & ~mask) | (|(ist & ien));
  always #4 SYS_CLK = ~SYS_CLK;
  rng_word_gen dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));
  // ==========================================================
  // model; the access is handled before the push, as reads see old state
  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {run, ha, mask, ei, uf, lre, sv, ist, ien} = 0;
      lvl = 0;
      cyc = 0;
    end else begin
      lv0 = lvl;
      if (take) begin
        exp_rd = 0;
        rnd = 0;
        exp_err = !(PADDR inside {RNG_CONTROL_ADDR, RNG_STATUS_ADDR, ENTROPY_SEED_INPUT_ADDR,
          RANDOM_OUTPUT_FIFO_ADDR, IRQ_STATUS_ADDR, IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR});
        case ({PWRITE, PADDR})
          {1'b1, RNG_CONTROL_ADDR}: begin
            if (PWDATA[3]) ei = 0;
            // the counter only starts on the edge after run is taken
            if (PWDATA[0] && !run) cyc = -1;
            run = run | PWDATA[0];
            ha = ha | PWDATA[1];
            mask = PWDATA[2];
          end
          {1'b0, RNG_CONTROL_ADDR}: exp_rd = {29'h0, mask, ha, run};
          {1'b0, RNG_STATUS_ADDR}: begin
            exp_rd = {8'h0, FIFO_CAPACITY, 8'(lvl), 4'h0, ei, uf, lre, sv};
            uf = 0;
          end
          {1'b0, RANDOM_OUTPUT_FIFO_ADDR}: begin
            rnd = lvl > 0;
            lre = lvl == 0;
            if (lvl == 0) {ei, uf, ist[0], sv} = {3'h7, sv | ha};
            else lvl = lvl - 1;
          end
          {1'b0, IRQ_STATUS_ADDR}: exp_rd = {30'h0, ist};
          {1'b1, IRQ_CLEAR_ADDR}: ist = ist & ~PWDATA[1:0];
          {1'b1, IRQ_ENABLE_ADDR}: ien = PWDATA[1:0];
          {1'b0, IRQ_ENABLE_ADDR}: exp_rd = {30'h0, ien};
          default: ;
        endcase
      end
      if (run) begin
        // full is judged before this edge's pop, as in the design
        if (cyc % 256 == 255 && lv0 < 16) begin
          lvl = lvl + 1;
          if (lvl == 16) ist[1] = 1;
        end
        cyc = cyc + 1;
      end
    end
  end
  // ==========================================================
  // tasks
  task check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // waits for ready as long as it takes; only the watchdog ends a hang
  task bus(input logic w, input logic [31:0] a, d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    if (!w && !rnd) check("rdata", PRDATA, exp_rd);
    check("slverr", {31'h0, PSLVERR}, {31'h0, exp_err});
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge SYS_CLK);
  endtask : bus
  task irq_chk;
    repeat (3) @(posedge SYS_CLK);
    check("irq", {31'h0, IRQ}, {31'h0, irq_m});
  endtask : irq_chk
  task end_of_test;
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // sequence
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    SYS_RST <= 0;
    repeat (300) @(posedge SYS_CLK);
    bus(0, RNG_STATUS_ADDR, 0);
    bus(0, RANDOM_OUTPUT_FIFO_ADDR, 0);
    bus(0, RNG_STATUS_ADDR, 0);
    bus(0, RNG_STATUS_ADDR, 0);
    irq_chk;
    bus(1, RNG_CONTROL_ADDR, 32'h4);
    irq_chk;
    bus(1, RNG_CONTROL_ADDR, 32'h8);
    irq_chk;
    bus(1, IRQ_ENABLE_ADDR, 32'h3);
    irq_chk;
    bus(0, IRQ_STATUS_ADDR, 0);
    bus(1, IRQ_CLEAR_ADDR, 32'h1);
    irq_chk;
    bus(1, ENTROPY_SEED_INPUT_ADDR, $random(seed));
    bus(0, ENTROPY_SEED_INPUT_ADDR, 0);
    bus(1, RNG_STATUS_ADDR, $random(seed));
    bus(0, 32'h001a0020 + ($random(seed) & 32'h3c), 0);
    bus(1, RNG_CONTROL_ADDR, 32'h7);
    bus(1, RNG_CONTROL_ADDR, 32'h0);
    bus(0, RNG_CONTROL_ADDR, 0);
    for (i = 0; i < 20; i++) begin
      repeat (230) @(posedge SYS_CLK);
      bus(0, RNG_STATUS_ADDR, 0);
    end
    irq_chk;
    // drain right after a push so no push meets a pop at full level
    wait (cyc % 256 == 10);
    @(posedge SYS_CLK);
    // software polls the level before it reads the fifo
    bus(0, RNG_STATUS_ADDR, 0);
    for (i = 0; i < 17; i++) bus(0, RANDOM_OUTPUT_FIFO_ADDR, 0);
    bus(0, RNG_STATUS_ADDR, 0);
    irq_chk;
    SYS_RST <= 1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 0;
    @(posedge SYS_CLK);
    bus(0, RNG_CONTROL_ADDR, 0);
    bus(0, RNG_STATUS_ADDR, 0);
    end_of_test;
  end
endmodule : random_word_generator_fifo_test
